// ---- logic/bgc_defs.svh ----
`ifndef BGC_DEFS_SVH
`define BGC_DEFS_SVH
// ============================================================
// Overview of operation
// - Middle mode: byte holds four 2-bit pixels, 320 by 192 screen.
// - Lowest mode: 4-bit pixels, sixteen values, halved vertical, 160 by 96.
// - Lowest mode offers two pages of half memory each; host edits hidden one.
// - Lowest mode: even lines page zero, odd page one, page bit forces line LSB.
// - Multi-bit modes map pixel through 16x8 table to DAC; three bits drive RGB.
// - Port group select decodes two address lines; host read sets buffer direction.
// - Write data held until next 4 MHz rising edge after strobes go high.
// - Port zero latches vertical coordinate, port one horizontal coordinate.
// - Latched coordinates reach memory only while host access window is open.
// - Port three access: row strobe, column switch on 4 MHz edge, then column strobe.
// - Port three write drives memory write low; read puts memory data on bus.
// - Columns 64 to 79 are remapped so 80x192 fits the 16K RAM.
// - Column counter steps per 500 ns byte, clears per line; line counter on line clock.
// - During refresh memory write line stays high; strobes from own timing chain.
// - Open control stops refresh and grants host unlimited memory access.
// - Table write: data from port zero, index in port two low bits, in field blank.
// - Host access only in line blank, field blank or open; port two reports them.
// - Highest mode shifts each byte out at 16 MHz as one-bit pixels.
// - Pixel shift runs 4 MHz in lowest mode, 8 MHz in middle mode.
// - In 80-column text mode the access window is delayed by two pixel clocks.
// - Field blank gated by upper line bits so lines 192 to 255 are text only.
// - DAC output register disabled in line blank, field blank and highest mode.
// ============================================================
`define BGC_PORT_VCOORD 2'h0
`define BGC_PORT_HCOORD 2'h1
`define BGC_PORT_CTRL 2'h2
`define BGC_PORT_PIXEL 2'h3
`define BGC_CTRL_TABLE_WRITE_STROBE 4
`define BGC_CTRL_OPEN_N 5
`define BGC_CTRL_PAGE 6
`define BGC_CTRL_RST 8'h30
`define BGC_STAT_LBLANK 0
`define BGC_STAT_FIELD_BLANK_GATED 1
`define BGC_STAT_OPEN 2
`define BGC_TEXT_ONLY_TOP 2'h3
`define BGC_SYS_MHZ 125
`define BGC_PIX_MHZ 16
`define BGC_PIX_DIV (`BGC_SYS_MHZ / `BGC_PIX_MHZ)
`define BGC_BYTE_NS 500
`define BGC_BYTE_TICKS (`BGC_BYTE_NS * `BGC_PIX_MHZ / 1000)
`define BGC_PH_COL 3'h4
`define BGC_PH_CAS 3'h5
`define BGC_PH_LOAD 3'h7
`define BGC_RGB_LO 5
`endif

// ---- logic/bgc_pkg.sv ----
package bgc_pkg;
  typedef enum logic [2:0] {BGC_IDLE, BGC_RROW, BGC_RCOL, BGC_RCAS,
                            BGC_HROW, BGC_HCOL, BGC_HCAS} bgc_state_e;
  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] addr;
    logic [7:0] data;
    logic line_clock;
    logic frame_reset;
    logic line_blank_n;
    logic field_blank_n;
    logic text80;
    logic one_bit_mode_enable;
    logic shift_rate_select;
    logic [7:0] mem_dq;
  } bgc_pins_s;
  typedef struct packed {
    bgc_pins_s s1;
    bgc_pins_s s2;
    logic [2:0] div;
    logic [2:0] phase;
    logic [1:0] win_dly;
    logic [7:0] vcoord;
    logic [7:0] hcoord;
    logic [7:0] ctrl;
    logic [7:0] hold;
    logic wr_act_d;
    logic pend;
    logic [1:0] pend_port;
    bgc_state_e st;
    logic [13:0] maddr;
    logic host_wr;
    logic acc_done;
    logic [7:0] rdata;
    logic [7:0] hdata;
    logic hoe;
    logic [6:0] col;
    logic [7:0] line;
    logic lclk_d;
    logic [7:0] shreg;
    logic [15:0][7:0] lut;
    logic [7:0] grey;
    logic mono;
  } bgc_regs_s;
endpackage

// ---- logic/bgc_graphics_top.sv ----
`timescale 1ns/10ps
`include "bgc_defs.svh"
module bgc_graphics_top #(
  parameter int PIX_DIV = `BGC_PIX_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_graphics_port_select_n,
  input wire logic i_host_rd_n,
  input wire logic i_host_wr_n,
  input wire logic [1:0] i_host_addr,
  input wire logic [7:0] i_host_data,
  output logic [7:0] o_host_data,
  output logic o_host_data_oe,
  input wire logic i_line_clock,
  input wire logic i_frame_reset,
  input wire logic i_line_blank_n,
  input wire logic i_field_blank_n,
  input wire logic i_text80,
  input wire logic i_one_bit_mode_enable,
  input wire logic i_shift_rate_select,
  output logic [6:0] o_mem_addr,
  output logic o_memory_row_strobe_n,
  output logic o_memory_column_strobe_n,
  output logic o_memory_read_write,
  input wire logic [7:0] i_mem_dq,
  output logic [7:0] o_mem_dq,
  output logic o_mem_dq_oe,
  output logic [7:0] o_grey_level_output,
  output logic [2:0] o_rgb,
  output logic o_mono_pixel,
  output bgc_pkg::bgc_state_e o_state
);
  import bgc_pkg::*;

  if (PIX_DIV < 2 || PIX_DIV > 8)
  begin : g_bad_div
    $error("PIX_DIV must lie between 2 and 8");
  end

  // ============================================================
  // Helpers
  // Columns 64..79 of every line go to a common top block of the RAM
  function automatic logic [13:0] bgc_map(input logic [7:0] ln, input logic [6:0] cl);
    logic [13:0] a;
    a = {ln, cl[5:0]};
    if (cl[6])
    begin
      a = {2'h3, ln, cl[3:0]};
    end
    return a;
  endfunction

  function automatic logic bgc_is_col(input bgc_state_e s);
    return (s == BGC_RCOL) || (s == BGC_RCAS) || (s == BGC_HCOL) || (s == BGC_HCAS);
  endfunction

  // ============================================================
  // State
  bgc_regs_s r_r;
  bgc_regs_s r_nxt;
  bgc_pins_s pins;
  bgc_pins_s p;
  logic sel;
  logic wr;
  logic rd;
  logic port3;
  logic pix_tick;
  logic t4;
  logic t8;
  logic lbl;
  logic fbg;
  logic open_w;
  logic win_raw;
  logic win;
  logic blank;
  logic low_mode;
  logic commit;
  logic lut_we;
  logic ref_load;
  logic [3:0] pix_idx;
  logic [7:0] ref_line;

  assign pins = '{sel_n: i_graphics_port_select_n, rd_n: i_host_rd_n, wr_n: i_host_wr_n,
                  addr: i_host_addr, data: i_host_data, line_clock: i_line_clock,
                  frame_reset: i_frame_reset, line_blank_n: i_line_blank_n,
                  field_blank_n: i_field_blank_n, text80: i_text80,
                  one_bit_mode_enable: i_one_bit_mode_enable,
                  shift_rate_select: i_shift_rate_select, mem_dq: i_mem_dq};

  always_comb
  begin
    r_nxt = r_r;
    // First stage is read only by the second
    r_nxt.s1 = pins;
    r_nxt.s2 = r_r.s1;
    p = r_r.s2;
    sel = !p.sel_n;
    wr = sel && !p.wr_n;
    rd = sel && !p.rd_n;
    port3 = sel && (p.addr == `BGC_PORT_PIXEL) && (wr || rd);
    low_mode = !p.one_bit_mode_enable && !p.shift_rate_select;

    // Pixel clock divider; 4 and 8 MHz are phases of it
    pix_tick = (r_r.div == 3'(PIX_DIV - 1));
    r_nxt.div = pix_tick ? 3'h0 : r_r.div + 3'h1;
    if (pix_tick)
    begin
      r_nxt.phase = r_r.phase + 3'h1;
    end
    t4 = pix_tick && (r_r.phase[1:0] == 2'h3);
    t8 = pix_tick && r_r.phase[0];

    // Access window and blanking
    lbl = !p.line_blank_n;
    fbg = !p.field_blank_n || (r_r.line[7:6] == `BGC_TEXT_ONLY_TOP);
    open_w = !r_r.ctrl[`BGC_CTRL_OPEN_N];
    win_raw = lbl || fbg || open_w;
    if (pix_tick)
    begin
      r_nxt.win_dly = {r_r.win_dly[0], win_raw};
    end
    win = p.text80 ? r_r.win_dly[1] : win_raw;

    // Host write: capture while strobe low, commit on the 4 MHz edge after it ends
    r_nxt.wr_act_d = wr;
    if (wr)
    begin
      r_nxt.hold = p.data;
      r_nxt.pend_port = p.addr;
    end
    if (r_r.wr_act_d && !wr)
    begin
      r_nxt.pend = 1'b1;
    end
    commit = r_r.pend && t4;
    lut_we = 1'b0;
    if (commit)
    begin
      r_nxt.pend = 1'b0;
      case (r_r.pend_port)
        `BGC_PORT_VCOORD: r_nxt.vcoord = r_r.hold;
        `BGC_PORT_HCOORD: r_nxt.hcoord = r_r.hold;
        `BGC_PORT_CTRL:
        begin
          r_nxt.ctrl = r_r.hold;
          // Table write control acts on its return high, only in field blank
          lut_we = fbg && !r_r.ctrl[`BGC_CTRL_TABLE_WRITE_STROBE] && r_r.hold[`BGC_CTRL_TABLE_WRITE_STROBE];
        end
        default: r_nxt.pend = 1'b0;
      endcase
    end
    if (lut_we)
    begin
      r_nxt.lut[r_r.ctrl[3:0]] = r_r.vcoord;
    end

    // Host read data, registered; direction follows the read strobe
    r_nxt.hoe = rd;
    case (p.addr)
      `BGC_PORT_CTRL: r_nxt.hdata = {5'h00, open_w, fbg, lbl};
      `BGC_PORT_PIXEL: r_nxt.hdata = r_r.rdata;
      default: r_nxt.hdata = 8'h00;
    endcase

    // Line counter follows the main-board line clock
    r_nxt.lclk_d = p.line_clock;
    if (p.frame_reset)
    begin
      r_nxt.line = 8'h00;
    end
    else if (p.line_clock && !r_r.lclk_d)
    begin
      r_nxt.line = r_r.line + 8'h01;
    end
    if (win)
    begin
      r_nxt.col = 7'h00;
    end

    // Lowest mode: page bit replaces line LSB, so each memory line shows twice
    ref_line = low_mode ? {r_r.line[7:1], r_r.ctrl[`BGC_CTRL_PAGE]} : r_r.line;

    // Memory cycle sequencer
    if (!port3)
    begin
      r_nxt.acc_done = 1'b0;
    end
    ref_load = 1'b0;
    case (r_r.st)
      BGC_IDLE:
      begin
        if (port3 && win && !r_r.acc_done)
        begin
          r_nxt.st = BGC_HROW;
          r_nxt.maddr = bgc_map(r_r.vcoord, r_r.hcoord[6:0]);
          r_nxt.host_wr = wr;
          r_nxt.acc_done = 1'b1;
        end
        else if (!win && (r_r.phase == 3'h0))
        begin
          // Open window also stops refresh; host then owns DRAM refresh
          r_nxt.st = BGC_RROW;
          r_nxt.maddr = bgc_map(ref_line, r_r.col);
        end
      end
      BGC_RROW: if (pix_tick && (r_r.phase == `BGC_PH_COL - 3'h1)) r_nxt.st = BGC_RCOL;
      BGC_RCOL: if (pix_tick) r_nxt.st = BGC_RCAS;
      BGC_RCAS:
      begin
        if (pix_tick && (r_r.phase == `BGC_PH_LOAD))
        begin
          ref_load = 1'b1;
          r_nxt.st = BGC_IDLE;
          r_nxt.col = r_r.col + 7'h01;
        end
      end
      BGC_HROW: if (t4) r_nxt.st = BGC_HCOL;
      // One pixel tick of settling before the column strobe
      BGC_HCOL: if (pix_tick) r_nxt.st = BGC_HCAS;
      BGC_HCAS:
      begin
        if (!r_r.host_wr)
        begin
          r_nxt.rdata = p.mem_dq;
        end
        if (!port3)
        begin
          r_nxt.st = BGC_IDLE;
        end
      end
      default: r_nxt.st = BGC_IDLE;
    endcase

    // Pixel extraction; middle mode leaves junk in the lower index bits
    if (ref_load)
    begin
      r_nxt.shreg = p.mem_dq;
    end
    else if (p.one_bit_mode_enable)
    begin
      if (pix_tick) r_nxt.shreg = {r_r.shreg[6:0], 1'b0};
    end
    else if (p.shift_rate_select)
    begin
      if (t8) r_nxt.shreg = {r_r.shreg[5:0], 2'h0};
    end
    else if (t4)
    begin
      r_nxt.shreg = {r_r.shreg[3:0], 4'h0};
    end

    pix_idx = fbg ? r_r.ctrl[3:0] : r_r.shreg[7:4];
    blank = lbl || fbg || p.one_bit_mode_enable;
    r_nxt.grey = blank ? 8'h00 : r_r.lut[pix_idx];
    r_nxt.mono = p.one_bit_mode_enable && !lbl && !fbg && r_r.shreg[7];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      r_r <= '0;
      r_r.ctrl <= `BGC_CTRL_RST;
      r_r.st <= BGC_IDLE;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ============================================================
  // Outputs
  assign o_host_data = r_r.hdata;
  assign o_host_data_oe = r_r.hoe;
  assign o_mem_addr = bgc_is_col(r_r.st) ? r_r.maddr[13:7] : r_r.maddr[6:0];
  assign o_memory_row_strobe_n = (r_r.st == BGC_IDLE);
  assign o_memory_column_strobe_n = !((r_r.st == BGC_RCAS) || (r_r.st == BGC_HCAS));
  assign o_memory_read_write = !((r_r.st == BGC_HCAS) && r_r.host_wr);
  assign o_mem_dq = r_r.hold;
  assign o_mem_dq_oe = (r_r.st == BGC_HCAS) && r_r.host_wr;
  assign o_grey_level_output = r_r.grey;
  assign o_rgb = r_r.grey[`BGC_RGB_LO +: 3];
  assign o_mono_pixel = r_r.mono;
  assign o_state = r_r.st;

  // ============================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  a_refresh_write_blocked: assert property (
    (r_r.st inside {BGC_RROW, BGC_RCOL, BGC_RCAS}) |-> o_memory_read_write)
    else $error("write line low during refresh");
  a_host_write_low: assert property (
    (r_r.st == BGC_HCAS && r_r.host_wr) |-> !o_memory_read_write && o_mem_dq_oe)
    else $error("port three write did not drive write line low");
  a_col_on_4mhz: assert property (
    (r_r.st == BGC_HROW && r_nxt.st == BGC_HCOL) |-> t4)
    else $error("column switch off the 4 MHz edge");
  a_cas_after_mux: assert property (
    $fell(o_memory_column_strobe_n) |-> $past(bgc_is_col(r_r.st)) && !o_memory_row_strobe_n)
    else $error("column strobe without settled column address");
  a_host_in_window: assert property (
    (r_r.st == BGC_IDLE && r_nxt.st == BGC_HROW) |-> win)
    else $error("host memory cycle outside access window");
  a_dac_blanked: assert property (
    blank |=> (o_grey_level_output == 8'h00))
    else $error("DAC register not disabled");
  a_text_only_lines: assert property (
    (r_r.line[7:6] == 2'h3) |=> (o_grey_level_output == 8'h00) && !o_mono_pixel)
    else $error("graphics in text-only lines");
  a_frame_clear: assert property (
    p.frame_reset |=> (r_r.line == 8'h00))
    else $error("line counter not cleared by frame reset");
  a_col_step: assert property (
    ref_load && !win |=> (r_r.col == $past(r_r.col) + 7'h01))
    else $error("column counter did not step");
  a_open_no_refresh: assert property (
    (r_r.st == BGC_IDLE && open_w) |=> !(r_r.st inside {BGC_RROW, BGC_RCOL, BGC_RCAS}))
    else $error("refresh started while open");
  a_one_bit_mode_enable_shift: assert property (
    (p.one_bit_mode_enable && pix_tick && !ref_load) |=> (r_r.shreg[7:1] == $past(r_r.shreg[6:0])))
    else $error("one-bit shift wrong");

  c_host_write: cover property (r_r.st == BGC_HCAS && r_r.host_wr);
  c_host_read: cover property (r_r.st == BGC_HCAS && !r_r.host_wr);
  c_refresh_load: cover property (ref_load);
  c_table_write: cover property (lut_we);
endmodule

// ---- verif/bgc_host_model.sv ----
`timescale 1ns/10ps
module bgc_host_model (
  input wire logic i_sys_clk,
  output logic o_sel_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [1:0] o_addr,
  output logic [7:0] o_data,
  input wire logic [7:0] i_rdata
);
  // No acknowledge exists, so every access is held long enough for a full memory cycle
  localparam int HOLD = 50;

  initial
  begin
    o_sel_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 2'h0;
    o_data = 8'h00;
  end

  // ==========================================
  // Port access cycles
  task automatic write_port(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_addr = a;
    o_data = d;
    o_sel_n = 1'b0;
    o_wr_n = 1'b0;
    repeat (HOLD) @(posedge i_sys_clk);
    #1;
    o_sel_n = 1'b1;
    o_wr_n = 1'b1;
    // Released bus shows the inverse, so a late commit picks up wrong data
    o_data = ~d;
    repeat (40) @(posedge i_sys_clk);
  endtask

  task automatic read_port(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_addr = a;
    o_sel_n = 1'b0;
    o_rd_n = 1'b0;
    repeat (HOLD) @(posedge i_sys_clk);
    d = i_rdata;
    #1;
    o_sel_n = 1'b1;
    o_rd_n = 1'b1;
    repeat (4) @(posedge i_sys_clk);
  endtask
endmodule

// ---- verif/bitmap_graphics_controller_tb_top.sv ----
`timescale 1ns/10ps
module bitmap_graphics_controller_tb_top;
  import bgc_pkg::*;
  localparam int PD = 7;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel_n, rd_n, wr_n, hoe, ras_n, cas_n, rw, mdq_oe, mono;
  logic lclk = 1'b0, frst = 1'b0, lb_n = 1'b1, fb_n = 1'b1, onebit = 1'b0, srs = 1'b1;
  logic [1:0] addr;
  logic [7:0] hdata, rdata, mdq_o, mdq_i, grey, dq_last;
  logic [6:0] maddr, row_q, hrow, hcol;
  logic [2:0] rgb;
  bgc_state_e st, st_d;
  logic [7:0] mem [16384];
  int n_errors = 0, n_tests = 0, rrow_cnt = 0, bad_rw = 0, n_oe = 0;

  always #4 clk = ~clk;

  bgc_graphics_top #(.PIX_DIV(PD)) i_dut (.i_sys_clk(clk), .i_rst(rst),
    .i_graphics_port_select_n(sel_n), .i_host_rd_n(rd_n), .i_host_wr_n(wr_n),
    .i_host_addr(addr), .i_host_data(hdata), .o_host_data(rdata), .o_host_data_oe(hoe),
    .i_line_clock(lclk), .i_frame_reset(frst), .i_line_blank_n(lb_n),
    .i_field_blank_n(fb_n), .i_text80(1'b0), .i_one_bit_mode_enable(onebit),
    .i_shift_rate_select(srs), .o_mem_addr(maddr), .o_memory_row_strobe_n(ras_n),
    .o_memory_column_strobe_n(cas_n), .o_memory_read_write(rw), .i_mem_dq(mdq_i),
    .o_mem_dq(mdq_o), .o_mem_dq_oe(mdq_oe), .o_grey_level_output(grey), .o_rgb(rgb),
    .o_mono_pixel(mono), .o_state(st));

  bgc_host_model i_host (.i_sys_clk(clk), .o_sel_n(sel_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_addr(addr), .o_data(hdata), .i_rdata(rdata));

  // ==========================================
  // Frame store model, undriven data bus shows inverse of last value
  initial foreach (mem[i]) mem[i] = 8'h00;
  assign mdq_i = cas_n ? ~dq_last : mem[{maddr, row_q}];
  always @(posedge clk)
  begin
    if (st == BGC_HROW || st == BGC_RROW) row_q <= maddr;
    if (st == BGC_HCAS) {hcol, hrow} <= {maddr, row_q};
    if (st == BGC_HCAS && !rw) mem[{maddr, row_q}] <= mdq_o;
    if (!cas_n) dq_last <= mdq_i;
    if (!rw && st != BGC_HCAS) bad_rw++;
    if (st == BGC_RROW && st_d != BGC_RROW) rrow_cnt++;
    if (hoe) n_oe++;
    st_d <= st;
  end

  // ==========================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [1:0] a, input logic [7:0] e);
    logic [7:0] d;
    int k;
    k = n_oe;
    i_host.read_port(a, d);
    check(nm, {8'h00, e}, {8'h00, d});
    check("read_oe", 16'h0001, {15'h0000, n_oe > k});
  endtask

  task automatic line_pulse;
    lclk = 1'b1;
    cyc(3);
    lclk = 1'b0;
    cyc(3);
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_errors++;
    finish_test();
  end

  // ==========================================
  // Tests
  initial
  begin
    int n0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    cyc(5);
    rd_chk("port0_read", 2'h0, 8'h00);
    rd_chk("status_idle", 2'h2, 8'h00);
    lb_n = 1'b0;
    cyc(4);
    rd_chk("status_lblank", 2'h2, 8'h01);
    i_host.write_port(2'h0, 8'd5);
    i_host.write_port(2'h1, 8'd70);
    i_host.write_port(2'h3, 8'h3C);
    check("remap_addr", 16'h3056, {2'b00, hcol, hrow});
    i_host.write_port(2'h1, 8'd3);
    i_host.write_port(2'h3, 8'hC3);
    check("plain_addr", 16'h0143, {2'b00, hcol, hrow});
    rd_chk("pixel_lo", 2'h3, 8'hC3);
    i_host.write_port(2'h1, 8'd70);
    rd_chk("pixel_hi", 2'h3, 8'h3C);
    check("rw_refresh", 16'h0000, bad_rw[15:0]);
    // Every table entry gets the same value so any pixel stream maps to it
    fb_n = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      i_host.write_port(2'h0, 8'hA5);
      i_host.write_port(2'h2, 8'h20 | i[7:0]);
      i_host.write_port(2'h2, 8'h30 | i[7:0]);
    end
    rd_chk("status_field_blank_gated", 2'h2, 8'h03);
    check("grey_field_blank_gated", 16'h0000, {8'h00, grey});
    frst = 1'b1;
    cyc(4);
    frst = 1'b0;
    lb_n = 1'b1;
    fb_n = 1'b1;
    for (int m = 1; m >= 0; m--)
    begin
      srs = m[0];
      cyc(200);
      repeat (8)
      begin
        cyc(13);
        check("grey_lut", 16'h00A5, {8'h00, grey});
        check("rgb_bits", 16'h0005, {13'h0000, rgb});
      end
    end
    onebit = 1'b1;
    cyc(100);
    check("grey_onebit", 16'h0000, {8'h00, grey});
    check("mono_dark", 16'h0000, {15'h0000, mono});
    onebit = 1'b0;
    n0 = rrow_cnt;
    cyc(80 * PD);
    check("refresh_rate", 16'd10, 16'(rrow_cnt - n0));
    frst = 1'b1;
    cyc(4);
    frst = 1'b0;
    repeat (191) line_pulse();
    rd_chk("status_line191", 2'h2, 8'h00);
    line_pulse();
    rd_chk("status_line192", 2'h2, 8'h02);
    // Back to the top of the frame so only the open control can stop refresh
    frst = 1'b1;
    cyc(4);
    frst = 1'b0;
    cyc(4);
    i_host.write_port(2'h2, 8'h10);
    n0 = rrow_cnt;
    cyc(300);
    check("open_no_refresh", 16'h0000, 16'(rrow_cnt - n0));
    rd_chk("status_open", 2'h2, 8'h04);
    finish_test();
  end
endmodule
